// *** rtl/tsra_top.sv ***
/*
 Register access and data format logic of a serial temperature sensor:
 converter control with shutdown, formatted temperature word, and the
 three-wire serial slave (chip select, serial clock, data line).
 Assumes a converter on mclk_in that pulses conv_in.done with a result, and
 a host that drives serial_clock_line_in only while chip select is low.
*/
`timescale 1ns/10ps
`include "tsra_consts.svh"
module tsra_top #(
	parameter logic [15:0] ID_VALUE = `TSRA_ID_DEFAULT // arbitrary value
) (
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	input  wire logic              ce_in,
	input  wire tsra_pkg::tsra_conv_s conv_in,
	input  wire logic              conv_busy_in,
	output logic                   conv_enable_out,
	output logic [1:0]             conv_res_out,
	output logic                   shutdown_active_out,
	input  wire logic              serial_clock_line_in,
	input  wire logic              cs_n_in,
	input  wire logic              sio_in,
	output logic                   sio_out,
	output logic                   sio_oe_out
);
	import tsra_pkg::*;

	function automatic logic [15:0] fmt_temp(input logic [15:0] raw, input logic [1:0] res);
		logic [15:0] mask;
		mask = `TSRA_MASK_16;
		case (res)
			`TSRA_RES_13: mask = `TSRA_MASK_13;
			`TSRA_RES_14: mask = `TSRA_MASK_14;
			`TSRA_RES_15: mask = `TSRA_MASK_15;
			default:      mask = `TSRA_MASK_16;
		endcase
		return raw & mask;
	endfunction

	// pointer decode shared by read mux and write strobes
	function automatic logic [2:0] reg_sel(input logic [7:0] cmd);
		logic [2:0] sel;
		sel = 3'h0;
		if (cmd[6:3] == 4'h0)
		begin
			case (cmd[2:0])
				`TSRA_PTR_CTRL:  sel = `TSRA_PTR_CTRL;
				`TSRA_PTR_THIGH: sel = `TSRA_PTR_THIGH;
				`TSRA_PTR_TLOW:  sel = `TSRA_PTR_TLOW;
				`TSRA_PTR_ID:    sel = `TSRA_PTR_ID;
				default:         sel = 3'h0;
			endcase
		end
		return sel;
	endfunction

	logic        rst_meta_q;
	logic        rst_sync_q;
	logic        sd_meta_q;
	logic        sd_sync_q;
	logic [1:0]  res_meta_q;
	logic [1:0]  res_sync_q;
	logic        shutdown_q;
	logic        conv_en_q;
	logic [15:0] temp_raw_q;
	logic [15:0] temp_fmt_q;
	logic        conv_tgl_q;
	// written on the link clock, read here only through the two-flop copies
	logic [15:0] ctrl_q;

	// power-on reset, released through two flops
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// control bits from the link domain; quasi-static, so a 2-flop level sync
	always_ff @(posedge mclk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			sd_meta_q  <= 1'b0;
			sd_sync_q  <= 1'b0;
			res_meta_q <= `TSRA_RES_13;
			res_sync_q <= `TSRA_RES_13;
		end
		else if (ce_in)
		begin
			sd_meta_q  <= ctrl_q[`TSRA_CTRL_SD_BIT];
			sd_sync_q  <= sd_meta_q;
			res_meta_q <= ctrl_q[`TSRA_CTRL_RES_HI:`TSRA_CTRL_RES_LO];
			res_sync_q <= res_meta_q;
		end
	end

	wire conv_idle = !conv_busy_in && !conv_in.done;

	always_ff @(posedge mclk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			conv_en_q  <= 1'b0;
			shutdown_q <= 1'b0;
		end
		else if (ce_in)
		begin
			conv_en_q  <= !sd_sync_q;
			shutdown_q <= sd_sync_q && (shutdown_q || conv_idle);
		end
	end

	always_ff @(posedge mclk_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			temp_raw_q <= 16'h0000;
			temp_fmt_q <= 16'h0000;
			conv_tgl_q <= 1'b0;
		end
		else if (ce_in)
		begin
			if (conv_in.done)
			begin
				temp_raw_q <= conv_in.data;
				conv_tgl_q <= ~conv_tgl_q;
			end
			temp_fmt_q <= fmt_temp(temp_raw_q, res_sync_q);
		end
	end

	assign conv_enable_out     = conv_en_q;
	assign conv_res_out        = res_sync_q;
	assign shutdown_active_out = shutdown_q;

	// link domain: frame state dies with chip select, since the clock stops
	wire frame_rst_n = rst_sync_q & ~cs_n_in;

	tsra_phase_e phase_q;
	logic [3:0]  cnt_q;
	logic [6:0]  shift_q;
	logic [7:0]  cmd_q;
	logic [15:0] thigh_q;
	logic [15:0] tlow_q;
	logic        tbit_q;
	logic        new_q;
	logic        snap_q;
	logic        seen_q;
	logic        tg_meta_q;
	logic        tg_sync_q;
	logic        sout_q;

	wire [3:0]  cnt_inc   = cnt_q + 4'h1;
	wire [7:0]  rx_byte   = {shift_q, sio_in};
	wire [2:0]  sel       = reg_sel(cmd_q);
	wire        in_temp   = (phase_q == PH_TEMP);
	wire        in_cmd    = (phase_q == PH_CMD);
	wire        in_data   = (phase_q == PH_DATA);
	wire        host_rd   = cmd_q[`TSRA_CMD_DIR_BIT];
	wire        temp_end  = in_temp && (cnt_q == `TSRA_BIT_TEMP_LAST);
	wire        cmd_end   = in_cmd && (cnt_q == `TSRA_BIT_CMD_LAST);
	wire        data_end  = in_data && (cnt_q == `TSRA_BIT_DATA_LAST);
	// zero in bit 7 means write
	wire        wr_phase  = in_data && !host_rd;
	wire        wr_hi     = wr_phase && (cnt_q == `TSRA_BIT_DATA_HI);
	wire        wr_lo     = wr_phase && (cnt_q == `TSRA_BIT_DATA_LAST);
	wire        res_full  = (ctrl_q[`TSRA_CTRL_RES_HI:`TSRA_CTRL_RES_LO] == `TSRA_RES_16);
	wire        wr_ctrl   = (sel == `TSRA_PTR_CTRL);
	wire        wr_thigh  = (sel == `TSRA_PTR_THIGH);
	wire        wr_tlow   = (sel == `TSRA_PTR_TLOW);

	// low bit is toggle below 16 bits
	wire        temp_lsb  = res_full ? temp_fmt_q[0] : (tbit_q ^ new_q);
	wire [15:0] temp_word = {temp_fmt_q[15:1], temp_lsb};

	// read mux, invalid pointer reads zero
	wire [15:0] rd_word =
		(sel == `TSRA_PTR_CTRL)  ? (ctrl_q & `TSRA_CTRL_WMASK) :
		(sel == `TSRA_PTR_THIGH) ? thigh_q :
		(sel == `TSRA_PTR_TLOW)  ? tlow_q :
		(sel == `TSRA_PTR_ID)    ? ID_VALUE :
		                           `TSRA_INVALID_READ;
	wire [15:0] out_word = in_temp ? temp_word : rd_word;

	always_ff @(posedge serial_clock_line_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			phase_q <= PH_TEMP;
			cnt_q   <= 4'h0;
			shift_q <= 7'h00;
		end
		else
		begin
			shift_q <= rx_byte[6:0];
			cnt_q   <= cnt_inc;
			if (temp_end || data_end)
			begin
				phase_q <= PH_CMD;
				cnt_q   <= 4'h0;
			end
			else if (cmd_end)
			begin
				phase_q <= PH_DATA;
				cnt_q   <= 4'h0;
			end
		end
	end

	// command byte cleared only at power-on
	always_ff @(posedge serial_clock_line_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			cmd_q <= `TSRA_CMD_RESET;
		end
		else if (cmd_end)
		begin
			cmd_q <= rx_byte;
		end
	end

	// writes taken regardless of shutdown; MSB latched at bit 8
	always_ff @(posedge serial_clock_line_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			ctrl_q  <= `TSRA_CTRL_RESET;
			thigh_q <= `TSRA_THIGH_RESET;
			tlow_q  <= `TSRA_TLOW_RESET;
		end
		else if (wr_hi)
		begin
			// status flags not modelled, so only the shutdown bit is kept
			if (wr_ctrl)
			begin
				ctrl_q[15:8] <= rx_byte & 8'h80;
			end
			if (wr_thigh)
			begin
				thigh_q[15:8] <= rx_byte;
			end
			if (wr_tlow)
			begin
				tlow_q[15:8] <= rx_byte;
			end
		end
		else if (wr_lo)
		begin
			if (wr_ctrl)
			begin
				ctrl_q[7:0] <= rx_byte & 8'hF6;
			end
			if (wr_thigh)
			begin
				thigh_q[7:0] <= rx_byte & 8'hE0;
			end
			if (wr_tlow)
			begin
				tlow_q[7:0] <= rx_byte & 8'hE0;
			end
		end
	end

	// conversion toggle crosses as a level; read only through tg_sync_q
	always_ff @(posedge serial_clock_line_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			tg_meta_q <= 1'b0;
			tg_sync_q <= 1'b0;
		end
		else
		begin
			tg_meta_q <= conv_tgl_q;
			tg_sync_q <= tg_meta_q;
		end
	end

	// decide early in the read, commit at read end
	// link clock only runs in frames, so the toggle copy is stale at the
	// first edge; by the third edge it holds the value seen at frame start
	always_ff @(posedge serial_clock_line_in or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			tbit_q <= 1'b0;
			new_q  <= 1'b0;
			snap_q <= 1'b0;
			seen_q <= 1'b0;
		end
		else if (in_temp && cnt_q == 4'h2)
		begin
			new_q  <= (tg_sync_q != seen_q);
			snap_q <= tg_sync_q;
		end
		else if (temp_end)
		begin
			// aborted reads leave the toggle alone
			tbit_q <= tbit_q ^ new_q;
			seen_q <= new_q ? snap_q : seen_q;
			new_q  <= 1'b0;
		end
	end

	// msb first, launched on falling clock
	always_ff @(negedge serial_clock_line_in or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
		begin
			sout_q <= 1'b0;
		end
		else
		begin
			sout_q <= out_word[`TSRA_BIT_TEMP_LAST - cnt_q];
		end
	end

	// first temperature bit must be valid before any clock edge
	assign sio_out    = (in_temp && cnt_q == 4'h0) ? temp_fmt_q[15] : sout_q;
	// released after the sixteenth edge so the host can drive the command
	assign sio_oe_out = !cs_n_in && (in_temp || (in_data && host_rd));

endmodule // tsra_top

// *** rtl/tsra_consts.svh ***
/*
 Constants for the temperature sensor register access block: command codes,
 register reset values, write masks and field positions.
 Assumes inclusion through its guard by design and bench files alike.
*/
// Function
// - 14-bit: sign D15, toggle D0, D1 zero.
// - 15-bit: sign D15, data 15:1, D0 toggle.
// - 16-bit: all bits two's-complement temperature.
// - temperature shifted out MSB byte, MSB first.
// - finish running conversion before stopping.
// - clearing shutdown bit resumes continuous conversions.
// - four registers reached through the command byte.
// - after power-up pointer selects temperature; here the 00h reset pointer decodes invalid and reads 0000h.
// - frame opens with temperature, then commands.
// - register access allowed in shutdown too.
// - shutdown keeps last completed conversion result.
// - command bit 7 gives data direction.
// - illegal address reads back 0000h.
// - pointer decode 1,2,3,7 valid; others invalid.
// - command byte resets to 00h, power-on only.
// - direction one reads, zero writes.
// - control bits 5:4 select 13..16 bits.
// - toggle bit inverts per read after conversion.
// - 16 temperature clocks, then line is input.
`ifndef TSRA_CONSTS_SVH
`define TSRA_CONSTS_SVH

`define TSRA_CMD_RESET     8'h00
`define TSRA_CMD_DIR_BIT   7
`define TSRA_PTR_CTRL      3'h1
`define TSRA_PTR_THIGH     3'h2
`define TSRA_PTR_TLOW      3'h3
`define TSRA_PTR_ID        3'h7
`define TSRA_CTRL_RESET    16'h0000
`define TSRA_CTRL_WMASK    16'h80F6
`define TSRA_CTRL_SD_BIT   15
`define TSRA_CTRL_RES_HI   5
`define TSRA_CTRL_RES_LO   4
`define TSRA_THIGH_RESET   16'h4880
`define TSRA_TLOW_RESET    16'h0000
`define TSRA_LIMIT_WMASK   16'hFFE0
`define TSRA_ID_DEFAULT    16'h5A01
`define TSRA_INVALID_READ  16'h0000
`define TSRA_BIT_TEMP_LAST 4'hF
`define TSRA_BIT_CMD_LAST  4'h7
`define TSRA_BIT_DATA_HI   4'h7
`define TSRA_BIT_DATA_LAST 4'hF
`define TSRA_RES_13        2'h0
`define TSRA_RES_14        2'h1
`define TSRA_RES_15        2'h2
`define TSRA_RES_16        2'h3
`define TSRA_MASK_13       16'hFFF8
`define TSRA_MASK_14       16'hFFFC
`define TSRA_MASK_15       16'hFFFE
`define TSRA_MASK_16       16'hFFFF

`endif

// *** rtl/tsra_pkg.sv ***
/*
 Types of the temperature sensor register access block.
 Assumes tsra_consts.svh is on the include path.
*/
`include "tsra_consts.svh"
package tsra_pkg;

	// serial frame phases after chip select falls
	typedef enum logic [1:0] {
		PH_TEMP,
		PH_CMD,
		PH_DATA
	} tsra_phase_e;

	// result handed over by the converter
	typedef struct packed {
		logic [15:0] data;
		logic        done;
	} tsra_conv_s;

endpackage

// *** dv/tsra_asserts.sv ***
/*
 Port checker for tsra_top: link framing, data line direction,
 resolution padding and shutdown handshake.
 Assumes binding to tsra_top; sees only its ports.
*/
`timescale 1ns/10ps
`include "tsra_consts.svh"
module tsra_asserts (
	input wire logic       mclk_in,
	input wire logic       rst_n_in,
	input wire logic       conv_busy_in,
	input wire logic       conv_enable_out,
	input wire logic [1:0] conv_res_out,
	input wire logic       shutdown_active_out,
	input wire logic       serial_clock_line_in,
	input wire logic       cs_n_in,
	input wire logic       sio_out,
	input wire logic       sio_oe_out
);
	logic [4:0] edge_cnt_q;

	// rising link edges so far; cleared while deselected
	always_ff @(posedge serial_clock_line_in or posedge cs_n_in)
	begin
		if (cs_n_in)
			edge_cnt_q <= 5'h00;
		else if (edge_cnt_q != 5'h1F)
			edge_cnt_q <= edge_cnt_q + 5'h01;
	end

	property p_oe_idle;
		@(posedge mclk_in) disable iff (!rst_n_in) cs_n_in |-> !sio_oe_out;
	endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("line driven while deselected");
	property p_temp_drive;
		@(posedge serial_clock_line_in) disable iff (!rst_n_in)
		!cs_n_in && edge_cnt_q < 5'h10 |-> sio_oe_out;
	endproperty
	a_temp_drive: assert property (p_temp_drive)
		else $error("temperature bit not driven");
	property p_cmd_input;
		@(posedge serial_clock_line_in) disable iff (!rst_n_in)
		!cs_n_in && edge_cnt_q >= 5'h10 && edge_cnt_q < 5'h18 |-> !sio_oe_out;
	endproperty
	a_cmd_input: assert property (p_cmd_input)
		else $error("line driven during command byte");
	property p_res14;
		@(posedge serial_clock_line_in) disable iff (!rst_n_in)
		!cs_n_in && edge_cnt_q == 5'h0E && conv_res_out == `TSRA_RES_14 |-> !sio_out;
	endproperty
	a_res14: assert property (p_res14)
		else $error("bit 1 not zero at 14 bits");
	property p_res13;
		@(posedge serial_clock_line_in) disable iff (!rst_n_in)
		!cs_n_in && (edge_cnt_q == 5'h0D || edge_cnt_q == 5'h0E) && conv_res_out == `TSRA_RES_13 |-> !sio_out;
	endproperty
	a_res13: assert property (p_res13)
		else $error("unused bit not zero at 13 bits");
	property p_sd_enable;
		@(posedge mclk_in) disable iff (!rst_n_in) shutdown_active_out |-> !$past(conv_enable_out);
	endproperty
	a_sd_enable: assert property (p_sd_enable)
		else $error("shutdown with conversions enabled");
	property p_sd_idle;
		@(posedge mclk_in) disable iff (!rst_n_in) $rose(shutdown_active_out) |-> !$past(conv_busy_in);
	endproperty
	a_sd_idle: assert property (p_sd_idle)
		else $error("shutdown during a conversion");
	property p_sd_exit;
		@(posedge mclk_in) disable iff (!rst_n_in) $rose(conv_enable_out) |-> ##[0:2] !shutdown_active_out;
	endproperty
	a_sd_exit: assert property (p_sd_exit)
		else $error("shutdown kept after resume");

	c_shutdown: cover property (@(posedge mclk_in) $rose(shutdown_active_out));
	c_cmd: cover property (@(posedge serial_clock_line_in) edge_cnt_q == 5'h17);
	c_res16: cover property (@(posedge mclk_in) conv_res_out == `TSRA_RES_16);
endmodule // tsra_asserts

bind tsra_top tsra_asserts i_tsra_asserts (.mclk_in, .rst_n_in, .conv_busy_in, .conv_enable_out,
	.conv_res_out, .shutdown_active_out, .serial_clock_line_in, .cs_n_in, .sio_out, .sio_oe_out);

// *** dv/tsra_host_model.sv ***
/*
 Host serial master model: chip select, link clock (12 ns, only in frames), data.
 Assumes the bench resolves the shared data line into sio_line_in.
*/
`timescale 1ns/10ps
module tsra_host_model (
	input  wire logic sio_line_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      sio_d_out,
	output logic      sio_oe_out
);
	initial
	begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sio_d_out = 1'b0;
		sio_oe_out = 1'b0;
	end

	// data set after falling edge, sampled at rising edge
	task automatic bit_xfer(input logic d, input logic drv, output logic q);
		sio_oe_out = drv;
		sio_d_out = d;
		#6 sclk_out = 1'b1;
		q = sio_line_in;
		#6 sclk_out = 1'b0;
	endtask

	// temperature first, then one command and its data
	// nt below 16 ends the temperature read early
	task automatic frame(input int nt, input bit do_cmd, input logic [7:0] cmd,
		input logic [15:0] wd, output logic [15:0] temp, output logic [15:0] rd);
		logic q;
		temp = 16'h0000;
		rd = 16'h0000;
		cs_n_out = 1'b0;
		for (int i = 0; i < nt; i++)
		begin
			bit_xfer(1'b0, 1'b0, q);
			temp = {temp[14:0], q};
		end
		if (do_cmd)
		begin
			for (int i = 7; i >= 0; i--)
				bit_xfer(cmd[i], 1'b1, q);
			// direction bit decides who drives the data
			for (int i = 15; i >= 0; i--)
			begin
				bit_xfer(wd[i], !cmd[7], q);
				rd = {rd[14:0], q};
			end
		end
		sio_oe_out = 1'b0;
		#6 cs_n_out = 1'b1;
		#24;
	endtask
endmodule // tsra_host_model

// *** dv/temp_sensor_register_access_tb_top.sv ***
/*
 Self-checking bench for tsra_top with converter stimulus.
 Assumes tsra_host_model drives the link side.
*/
`timescale 1ns/10ps
`include "tsra_consts.svh"
module temp_sensor_register_access_tb_top;
	import tsra_pkg::*;
	localparam logic [15:0] ID_V = 16'hC3A5; // arbitrary value
	logic       mclk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       ce_in = 1'b1;
	tsra_conv_s conv_in = '0;
	logic       conv_busy_in = 1'b0;
	logic       conv_enable_out, shutdown_active_out, sio_out, sio_oe_out;
	logic [1:0] conv_res_out;
	logic       serial_clock_line_in, cs_n_in, sio_in, h_d, h_oe;
	int         err_count = 0;
	int         checks = 0;
	int         cyc = 0;

	// released line shows a changing pattern, not the last bit
	assign sio_in = sio_oe_out ? sio_out : (h_oe ? h_d : mclk_in);

	tsra_top #(.ID_VALUE(ID_V)) i_tsra_top (.mclk_in, .rst_n_in, .ce_in, .conv_in, .conv_busy_in,
		.conv_enable_out, .conv_res_out, .shutdown_active_out, .serial_clock_line_in, .cs_n_in,
		.sio_in, .sio_out, .sio_oe_out);
	tsra_host_model i_tsra_host_model (.sio_line_in(sio_in), .sclk_out(serial_clock_line_in),
		.cs_n_out(cs_n_in), .sio_d_out(h_d), .sio_oe_out(h_oe));

	always #2 mclk_in = ~mclk_in;

	task automatic end_sim;
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			end_sim;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic convert(input logic [15:0] raw);
		@(negedge mclk_in) conv_busy_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		conv_in = '{data: raw, done: 1'b1};
		conv_busy_in = 1'b0;
		@(negedge mclk_in) conv_in.done = 1'b0;
		repeat (4) @(negedge mclk_in);
	endtask

	task automatic wait_sd(input logic v);
		// bounded wait, longer than the conversion here
		for (int i = 0; i < 40 && shutdown_active_out !== v; i++)
			@(negedge mclk_in);
	endtask

	task automatic t_power;
		logic [15:0] t, r;
		convert(16'h0C87);
		i_tsra_host_model.frame(16, 1, 8'h81, 16'h0000, t, r);
		chk({t[15:1], 1'b0}, 16'h0C80);
		chk(r, `TSRA_CTRL_RESET);
		chk({15'h0, conv_enable_out}, 16'h0001);
		$display("power test done");
	endtask

	task automatic t_res;
		logic [15:0] t0, t1, t2, r;
		logic [15:0] m [4] = '{`TSRA_MASK_13, `TSRA_MASK_14, `TSRA_MASK_15, `TSRA_MASK_16};
		for (int i = 0; i < 4; i++)
		begin
			i_tsra_host_model.frame(16, 1, 8'h01, {10'h0, i[1:0], 4'h0}, t0, r);
			convert(16'hEC07);
			i_tsra_host_model.frame(16, 0, 8'h00, 16'h0000, t1, r);
			i_tsra_host_model.frame(16, 0, 8'h00, 16'h0000, t2, r);
			chk({14'h0, conv_res_out}, i[15:0]);
			chk(i == 3 ? t1 : {t1[15:1], 1'b0}, i == 3 ? 16'hEC07 : 16'hEC06 & m[i]);
			chk(t2, t1);
			if (i < 3)
				chk({15'h0, t1[0] ^ t0[0]}, 16'h0001);
		end
		$display("resolution test done");
	endtask

	task automatic t_regs;
		logic [15:0] t, r;
		logic [7:0]  c [9] = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h00, 8'h04, 8'h05, 8'h06, 8'h09};
		logic [15:0] e [9] = '{16'h0036, 16'h5A20, 16'h5A20, ID_V, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
		for (int i = 0; i < 9; i++)
		begin
			i_tsra_host_model.frame(16, 1, c[i], 16'h5A36, t, r);
			i_tsra_host_model.frame(16, 1, c[i] | 8'h80, 16'h0000, t, r);
			chk(r, e[i]);
		end
		i_tsra_host_model.frame(16, 1, 8'h81, 16'h0000, t, r);
		chk(r, 16'h0036);
		$display("register test done");
	endtask

	task automatic t_sd;
		logic [15:0] t, r;
		@(negedge mclk_in) conv_busy_in = 1'b1;
		i_tsra_host_model.frame(16, 1, 8'h01, 16'h8030, t, r);
		repeat (20) @(negedge mclk_in);
		chk({14'h0, shutdown_active_out, conv_enable_out}, 16'h0000);
		conv_in = '{data: 16'h0C80, done: 1'b1};
		conv_busy_in = 1'b0;
		@(negedge mclk_in) conv_in.done = 1'b0;
		wait_sd(1'b1);
		chk({14'h0, shutdown_active_out, conv_enable_out}, 16'h0002);
		i_tsra_host_model.frame(16, 1, 8'h81, 16'h0000, t, r);
		chk(t, 16'h0C80);
		chk(r, 16'h8030);
		i_tsra_host_model.frame(16, 1, 8'h01, 16'h0030, t, r);
		wait_sd(1'b0);
		chk({14'h0, shutdown_active_out, conv_enable_out}, 16'h0001);
		$display("shutdown test done");
	endtask

	task automatic t_early;
		logic [15:0] t, r;
		convert(16'h5780);
		i_tsra_host_model.frame(4, 0, 8'h00, 16'h0000, t, r);
		chk(t, 16'h0005);
		i_tsra_host_model.frame(16, 0, 8'h00, 16'h0000, t, r);
		chk(t, 16'h5780);
		$display("early end test done");
	endtask

	initial
	begin
		repeat (4) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		t_power;
		t_res;
		t_regs;
		t_sd;
		t_early;
		end_sim;
	end
endmodule // temp_sensor_register_access_tb_top
